// File: fddi_framing_defines.svh
// constants for the framing, noise and repeat filter block
`ifndef FDDI_FRAMING_DEFINES_SVH
`define FDDI_FRAMING_DEFINES_SVH

// 4b symbol codes with control bit set
`define SYM_J 4'hd
`define SYM_K 4'hd
`define SYM_I 4'ha
`define SYM_H 4'h1
`define SYM_Q 4'h0
`define SYM_T 4'h5
`define SYM_R 4'h6
`define SYM_S 4'h7
`define SYM_V 4'h2
`define SYM_ZERO 4'h0

// line state codes
`define LS_ACTIVE 3'h0
`define LS_IDLE 3'h1
`define LS_UNKNOWN 3'h2
`define LS_MASTER 3'h4
`define LS_HALT 3'h5
`define LS_QUIET 3'h6
`define LS_NOISE 3'h7

// reframe holdoff: 1.5 byte times (in tenths of a byte), rounded up to bytes
`define JK_HOLD_TENTHS 15
`define JK_HOLD_BYTES ((`JK_HOLD_TENTHS + 9) / 10)
// recenter window: 2.8 byte times, longest time rounds down
`define RECENTER_TENTHS 28
`define RECENTER_BYTES (`RECENTER_TENTHS / 10)
// halt pairs sent on a violation
`define HALT_PAIRS 2

// link clock period in the bench, ns, and core period
`define LINK_PERIOD_NS 400
`define CORE_PERIOD_NS 50

`endif

// File: fddi_framing_pkg.sv
// types for the framing, noise and repeat filter block
package fddi_framing_pkg;
    typedef enum logic [2:0] {
        rf_idle_type = 3'h0,
        rf_repeat_type = 3'h1,
        rf_end_type = 3'h3,
        rf_halt_type = 3'h2
    } rf_state_type;
endpackage

// File: link_sync.sv
// two-flop synchroniser plus rising edge detect for the link clock and levels
module link_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_in, // core clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // levels from outside
    output logic [WIDTH-1:0] sync_out, // synchronised levels
    output logic [WIDTH-1:0] rise_out // one-cycle pulse on rising edge
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign sync_out = sync_q;
    assign rise_out = sync_q & ~last_q;
endmodule

// File: noise_qualifier.sv
// per-byte noise event and phy-invalid qualification
`include "fddi_framing_defines.svh"
module noise_qualifier (
    input wire logic signal_present_in, // synchronised signal detect
    input wire logic clock_present_in, // synchronised clock detect
    input wire logic [2:0] line_state_in, // current line state
    input wire logic [2:0] previous_line_state_in, // line state before unknown
    input wire logic [9:0] byte_in, // {c1,s1,c2,s2}
    input wire logic [9:0] previous_byte_in, // byte before this one
    output logic phy_invalid_flag_out, // phy invalid
    output logic noise_out // noise byte
);
    function automatic logic is_ctl(input logic c, input logic [3:0] s, input logic [3:0] v);
        is_ctl = c && (s == v);
    endfunction

    function automatic logic is_a(input logic c, input logic [3:0] s);
        is_a = !c || is_ctl(c, s, `SYM_R) || is_ctl(c, s, `SYM_S) || is_ctl(c, s, `SYM_T);
    endfunction

    function automatic logic is_ii(input logic [9:0] b);
        is_ii = is_ctl(b[9], b[8:5], `SYM_I) && is_ctl(b[4], b[3:0], `SYM_I);
    endfunction

    logic pair_ii;
    logic pair_jk;
    logic pair_ab;
    logic prev_ok;

    always_comb begin
        pair_ii = is_ii(byte_in);
        pair_jk = is_ctl(byte_in[9], byte_in[8:5], `SYM_J) && is_ctl(byte_in[4], byte_in[3:0], `SYM_K);
        pair_ab = is_a(byte_in[9], byte_in[8:5])
                  && (is_a(byte_in[4], byte_in[3:0]) || is_ctl(byte_in[4], byte_in[3:0], `SYM_I));
        prev_ok = (previous_line_state_in == `LS_ACTIVE) || (previous_line_state_in == `LS_IDLE);
        phy_invalid_flag_out = (line_state_in == `LS_HALT) || (line_state_in == `LS_QUIET)
                               || (line_state_in == `LS_MASTER) || (line_state_in == `LS_NOISE)
                               || ((line_state_in == `LS_UNKNOWN) && prev_ok);
        noise_out = (signal_present_in && !clock_present_in)
                    || (signal_present_in && clock_present_in && phy_invalid_flag_out
                        && !(pair_ii || pair_jk || pair_ab))
                    || (signal_present_in && clock_present_in && !phy_invalid_flag_out
                        && is_ii(previous_byte_in) && pair_ab);
    end
endmodule

// File: fddi_phy_framing_repeat_filter.sv
// receive framing hold, noise qualification and repeat filter for one phy
`include "fddi_framing_defines.svh"
module fddi_phy_framing_repeat_filter (
    input wire logic mclk_in, // 20 MHz core clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic link_clk_in, // byte clock from the link, sampled
    input wire logic [9:0] rx_byte_in, // {c1,s1,c2,s2}, valid at link edge
    input wire logic on_boundary_in, // pair is on the byte boundary
    input wire logic [2:0] line_state_in, // from line state detector
    input wire logic recenter_in, // elastic buffer recentered
    input wire logic signal_present_in, // signal detect pin
    input wire logic clock_present_in, // clock detect pin
    input wire logic active_transmit_in, // active transmit mode
    input wire logic transmit_parity_error_in, // parity error on this byte
    output logic [9:0] ind_byte_out, // byte towards the mac side
    output logic reframe_out, // one-cycle reframe pulse
    output logic stuff_byte_out, // stuff byte inserted before JK
    output logic noise_out, // noise byte flag, one core cycle long
    output logic phy_invalid_flag_out, // phy invalid level
    output logic [9:0] tx_byte_out // repeated byte downstream
);
    ////////////////////////////////////////////////////////////////////////
    // synchronise the link clock and pin levels
    logic [2:0] sync_lv;
    logic [2:0] sync_rise;
    logic byte_tick;

    link_sync #(.WIDTH(3)) u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .async_in({link_clk_in, signal_present_in, clock_present_in}),
        .sync_out(sync_lv),
        .rise_out(sync_rise)
    );
    // byte data is held a whole link period, so sampling at the synced edge is safe
    assign byte_tick = sync_rise[2];

    ////////////////////////////////////////////////////////////////////////
    // symbol decode helpers
    function automatic logic sym_is(input logic c, input logic [3:0] s, input logic [3:0] v);
        sym_is = c && (s == v);
    endfunction

    function automatic logic sym_viol(input logic c, input logic [3:0] s);
        sym_viol = sym_is(c, s, `SYM_V);
    endfunction

    logic c1;
    logic c2;
    logic [3:0] s1;
    logic [3:0] s2;
    logic pair_jk;
    logic pair_halt;
    logic has_idle;
    logic has_t;
    logic has_rs;
    logic has_viol;
    logic [9:0] mapped_byte;

    always_comb begin
        c1 = rx_byte_in[9];
        s1 = rx_byte_in[8:5];
        c2 = rx_byte_in[4];
        s2 = rx_byte_in[3:0];
        pair_jk = sym_is(c1, s1, `SYM_J) && sym_is(c2, s2, `SYM_K);
        pair_halt = sym_is(c1, s1, `SYM_H)
                    && (sym_is(c2, s2, `SYM_H) || sym_is(c2, s2, `SYM_Q));
        has_idle = sym_is(c1, s1, `SYM_I) || sym_is(c2, s2, `SYM_I);
        has_t = sym_is(c1, s1, `SYM_T) || sym_is(c2, s2, `SYM_T);
        has_rs = sym_is(c1, s1, `SYM_R) || sym_is(c1, s1, `SYM_S);
        has_viol = sym_viol(c1, s1) || sym_viol(c2, s2);
        mapped_byte = rx_byte_in;
        if (c1 != c2) begin
            mapped_byte = {1'b1, c1 ? s1 : `SYM_ZERO, 1'b1, c2 ? s2 : `SYM_ZERO};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // framing hold
    localparam logic [1:0] JK_HOLD = 2'(`JK_HOLD_BYTES);
    localparam logic [1:0] RC_WIN = 2'(`RECENTER_BYTES);
    logic [1:0] jk_age_q, jk_age_d;
    logic reframed_q, reframed_d;
    logic halt_block_q, halt_block_d;
    logic halt_recent_q, halt_recent_d;
    logic [1:0] rc_cnt_q, rc_cnt_d;
    logic reframe_d;
    logic stuff_d;
    logic halt_viol;
    logic in_active;
    logic in_idle;

    always_comb begin
        in_active = line_state_in == `LS_ACTIVE;
        in_idle = line_state_in == `LS_IDLE;
        jk_age_d = jk_age_q;
        reframed_d = reframed_q;
        halt_block_d = halt_block_q;
        halt_recent_d = halt_recent_q;
        rc_cnt_d = rc_cnt_q;
        reframe_d = 1'b0;
        stuff_d = 1'b0;
        halt_viol = 1'b0;
        if (byte_tick) begin
            if (jk_age_q != 2'h3) begin
                jk_age_d = jk_age_q + 2'h1;
            end
            if (in_active && (has_idle || has_t)) begin
                reframed_d = 1'b0;
            end
            if (pair_jk) begin
                // age counts from every jk seen, refused ones too
                jk_age_d = 2'h1;
                if (in_idle) begin
                    reframe_d = 1'b1;
                end else if (in_active && jk_age_q >= JK_HOLD) begin
                    if (on_boundary_in) begin
                        reframe_d = 1'b1;
                    end else if (!reframed_q) begin
                        reframe_d = 1'b1;
                    end
                end
                if (in_active && !on_boundary_in && reframed_q) begin
                    reframe_d = 1'b0;
                end
                if (in_active) begin
                    halt_block_d = 1'b1;
                end
                if (reframe_d) begin
                    reframed_d = 1'b1;
                    stuff_d = recenter_in || !on_boundary_in;
                end
            end
            // clear first, so a halt pair in the same byte wins
            if (recenter_in && !in_active) begin
                halt_block_d = 1'b0;
                if (rc_cnt_q >= RC_WIN) begin
                    halt_recent_d = 1'b0;
                end else begin
                    rc_cnt_d = rc_cnt_q + 2'h1;
                end
            end
            if (pair_halt && !on_boundary_in && (halt_block_q || halt_recent_q)) begin
                halt_viol = 1'b1;
            end else if (pair_halt && on_boundary_in) begin
                halt_recent_d = 1'b1;
                rc_cnt_d = 2'h0;
            end else if (pair_halt && in_idle) begin
                halt_recent_d = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // noise and phy invalid
    logic [9:0] prev_byte_q, prev_byte_d;
    logic [2:0] prev_ls_q, prev_ls_d;
    logic [2:0] last_ls_q, last_ls_d;
    logic [2:0] prev_ls_eff;
    logic pi_c;
    logic noise_c;
    logic noise_d;

    noise_qualifier u_noise (
        .signal_present_in(sync_lv[1]),
        .clock_present_in(sync_lv[0]),
        .line_state_in(line_state_in),
        .previous_line_state_in(prev_ls_eff),
        .byte_in(rx_byte_in),
        .previous_byte_in(prev_byte_q),
        .phy_invalid_flag_out(pi_c),
        .noise_out(noise_c)
    );

    always_comb begin
        prev_byte_d = prev_byte_q;
        prev_ls_d = prev_ls_q;
        last_ls_d = line_state_in;
        // on the cycle of a change the stored previous state is one step stale
        prev_ls_eff = (line_state_in != last_ls_q) ? last_ls_q : prev_ls_q;
        noise_d = 1'b0;
        if (byte_tick) begin
            prev_byte_d = rx_byte_in;
            noise_d = noise_c;
        end
        if (line_state_in != last_ls_q) begin
            prev_ls_d = last_ls_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // repeat filter
    fddi_framing_pkg::rf_state_type rf_q, rf_d;
    logic [1:0] halt_cnt_q, halt_cnt_d;
    logic [9:0] tx_d;
    logic viol;
    localparam logic [9:0] IDLE_PAIR = {1'b1, `SYM_I, 1'b1, `SYM_I};
    localparam logic [9:0] HALT_PAIR = {1'b1, `SYM_H, 1'b1, `SYM_H};
    localparam logic [1:0] HALT_N = 2'(`HALT_PAIRS);

    always_comb begin
        rf_d = rf_q;
        halt_cnt_d = halt_cnt_q;
        tx_d = tx_byte_out;
        viol = has_viol || halt_viol || transmit_parity_error_in;
        if (byte_tick) begin
            tx_d = mapped_byte;
            if (!active_transmit_in) begin
                rf_d = fddi_framing_pkg::rf_idle_type;
                tx_d = IDLE_PAIR;
            end else if (pair_jk) begin
                rf_d = fddi_framing_pkg::rf_repeat_type;
            end else if (sym_is(c1, s1, `SYM_I)) begin
                rf_d = fddi_framing_pkg::rf_idle_type;
                tx_d = IDLE_PAIR;
            end else begin
                unique case (rf_q)
                    fddi_framing_pkg::rf_idle_type: begin
                        tx_d = IDLE_PAIR;
                    end
                    fddi_framing_pkg::rf_repeat_type: begin
                        if (viol) begin
                            rf_d = fddi_framing_pkg::rf_halt_type;
                            halt_cnt_d = 2'h1;
                            tx_d = HALT_PAIR;
                        end else if (has_t) begin
                            rf_d = fddi_framing_pkg::rf_idle_type;
                        end else if (!c1 && !c2) begin
                            rf_d = fddi_framing_pkg::rf_end_type;
                        end
                    end
                    fddi_framing_pkg::rf_end_type: begin
                        if (viol || (has_rs && !has_t)) begin
                            rf_d = fddi_framing_pkg::rf_halt_type;
                            halt_cnt_d = 2'h1;
                            tx_d = HALT_PAIR;
                        end else if (has_t) begin
                            rf_d = fddi_framing_pkg::rf_repeat_type;
                        end
                    end
                    fddi_framing_pkg::rf_halt_type: begin
                        tx_d = HALT_PAIR;
                        if (halt_cnt_q >= HALT_N) begin
                            rf_d = fddi_framing_pkg::rf_idle_type;
                            tx_d = IDLE_PAIR;
                        end else begin
                            halt_cnt_d = halt_cnt_q + 2'h1;
                        end
                    end
                    default: begin
                        rf_d = fddi_framing_pkg::rf_idle_type;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            jk_age_q <= 2'h3;
            reframed_q <= 1'b0;
            halt_block_q <= 1'b0;
            halt_recent_q <= 1'b0;
            rc_cnt_q <= 2'h0;
            prev_byte_q <= 10'h000;
            prev_ls_q <= `LS_QUIET;
            last_ls_q <= `LS_QUIET;
            rf_q <= fddi_framing_pkg::rf_idle_type;
            halt_cnt_q <= 2'h0;
            ind_byte_out <= 10'h000;
            reframe_out <= 1'b0;
            stuff_byte_out <= 1'b0;
            noise_out <= 1'b0;
            phy_invalid_flag_out <= 1'b0;
            tx_byte_out <= 10'h000;
        end else begin
            jk_age_q <= jk_age_d;
            reframed_q <= reframed_d;
            halt_block_q <= halt_block_d;
            halt_recent_q <= halt_recent_d;
            rc_cnt_q <= rc_cnt_d;
            prev_byte_q <= prev_byte_d;
            prev_ls_q <= prev_ls_d;
            last_ls_q <= last_ls_d;
            rf_q <= rf_d;
            halt_cnt_q <= halt_cnt_d;
            ind_byte_out <= byte_tick ? mapped_byte : ind_byte_out;
            reframe_out <= reframe_d;
            stuff_byte_out <= stuff_d;
            noise_out <= noise_d;
            phy_invalid_flag_out <= pi_c;
            tx_byte_out <= tx_d;
        end
    end
endmodule

// File: fddi_frf_checker_sva.sv
// concurrent checks on the ports of the framing and repeat filter block
`include "fddi_framing_defines.svh"
module fddi_frf_checker (
    input wire logic mclk_in, // core clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic link_clk_in, // link byte clock
    input wire logic [9:0] rx_byte_in, // received pair
    input wire logic on_boundary_in, // pair on boundary
    input wire logic [2:0] line_state_in, // line state
    input wire logic recenter_in, // buffer recentering
    input wire logic active_transmit_in, // active transmit mode
    input wire logic [9:0] ind_byte_out, // byte to the mac side
    input wire logic reframe_out, // reframe pulse
    input wire logic stuff_byte_out, // stuff byte pulse
    input wire logic phy_invalid_flag_out, // phy invalid level
    input wire logic [9:0] tx_byte_out // byte downstream
);
    localparam logic [9:0] JK_PAIR = {1'b1, `SYM_J, 1'b1, `SYM_K};
    localparam logic [9:0] IDLE_PAIR = {1'b1, `SYM_I, 1'b1, `SYM_I};
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////////////
    // a whole byte taken while transmit is off; 6 cycles covers sync plus register
    sequence forced_byte_s;
        $rose(link_clk_in) && !active_transmit_in ##1 !active_transmit_in [*5];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////////////
    pi_invalid_a: assert property (line_state_in inside {`LS_HALT, `LS_QUIET, `LS_MASTER,
        `LS_NOISE} |=> phy_invalid_flag_out) else $error("phy invalid missing");
    pi_valid_a: assert property (line_state_in inside {`LS_ACTIVE, `LS_IDLE}
        |=> !phy_invalid_flag_out) else $error("phy invalid in active or idle");
    pi_unknown_a: assert property (line_state_in == `LS_UNKNOWN &&
        $past(line_state_in) inside {`LS_ACTIVE, `LS_IDLE} |=> phy_invalid_flag_out)
        else $error("phy invalid missing in unknown state");
    reframe_jk_a: assert property (reframe_out |-> rx_byte_in == JK_PAIR)
        else $error("reframe without a start pair");
    reframe_gap_a: assert property (reframe_out |=> !reframe_out [*7])
        else $error("two reframes within one byte");
    stuff_jk_a: assert property (stuff_byte_out |-> rx_byte_in == JK_PAIR &&
        (recenter_in || !on_boundary_in)) else $error("stuff byte without cause");
    force_idle_a: assert property (forced_byte_s |-> tx_byte_out == IDLE_PAIR)
        else $error("idle not forced");
    mixed_pair_a: assert property (ind_byte_out[9] == ind_byte_out[4])
        else $error("mixed pair reached the mac side");
endmodule
bind fddi_phy_framing_repeat_filter fddi_frf_checker i_fddi_frf_checker (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
    .rx_byte_in(rx_byte_in), .on_boundary_in(on_boundary_in), .line_state_in(line_state_in),
    .recenter_in(recenter_in), .active_transmit_in(active_transmit_in),
    .ind_byte_out(ind_byte_out), .reframe_out(reframe_out), .stuff_byte_out(stuff_byte_out),
    .phy_invalid_flag_out(phy_invalid_flag_out), .tx_byte_out(tx_byte_out));

// File: upstream_station.sv
// upstream station model driving the received link side
module upstream_station (
    input wire logic mclk_in, // core clock, only to launch a byte
    output logic link_clk_out, // recovered byte clock
    output logic [9:0] rx_byte_out, // received symbol pair
    output logic on_boundary_out, // pair on byte boundary
    output logic recenter_out, // buffer recentering
    output logic signal_present_out, // optical signal seen
    output logic clock_present_out // clock recovered
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk_out = 1'b0;
        rx_byte_out = 10'h35a;
        on_boundary_out = 1'b1;
        recenter_out = 1'b0;
        signal_present_out = 1'b1;
        clock_present_out = 1'b1;
    end
    // clock stands still between bytes; 7 ns offset keeps the edge off the core edge
    task automatic send(input logic [9:0] b, input logic onb, input logic rec);
        @(posedge mclk_in);
        rx_byte_out <= b;
        on_boundary_out <= onb;
        recenter_out <= rec;
        #7;
        link_clk_out <= 1'b1;
        #200;
        link_clk_out <= 1'b0;
        #190;
        // held until just before the next byte, then no longer valid
        rx_byte_out <= ~b;
    endtask
    task automatic pins(input logic sig, input logic clk);
        signal_present_out <= sig;
        clock_present_out <= clk;
    endtask
endmodule

// File: fddi_phy_framing_repeat_filter_tb.sv
// self-checking bench for the framing and repeat filter block
`include "fddi_framing_defines.svh"
module fddi_phy_framing_repeat_filter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] JK = {1'b1, `SYM_J, 1'b1, `SYM_K};
    localparam logic [9:0] II = {1'b1, `SYM_I, 1'b1, `SYM_I};
    localparam logic [9:0] HH = {1'b1, `SYM_H, 1'b1, `SYM_H};
    localparam logic [9:0] TR = {1'b1, `SYM_T, 1'b1, `SYM_R};
    localparam logic [9:0] VV = {1'b1, `SYM_V, 1'b1, `SYM_V};
    localparam logic [9:0] DD = 10'h0aa;
    localparam logic [9:0] NT = {1'b0, 4'h3, 1'b1, `SYM_T};
    localparam logic [9:0] ZT = {1'b1, `SYM_ZERO, 1'b1, `SYM_T};
    logic mclk = 1'b0;
    logic rst_n, link_clk, onb, rec, sig_ok, clk_ok, atx, perr, rf, st, nz, phy_inv;
    logic [2:0] ls;
    logic [2:0] pv = 3'h0;
    logic [9:0] rx_byte, ind, tx;
    int rf_cnt, st_cnt, nz_cnt, fail_count, num_checks;
    always #25 mclk = ~mclk;
    upstream_station i_upstream_station (.mclk_in(mclk), .link_clk_out(link_clk),
        .rx_byte_out(rx_byte), .on_boundary_out(onb), .recenter_out(rec),
        .signal_present_out(sig_ok), .clock_present_out(clk_ok));
    fddi_phy_framing_repeat_filter i_fddi_phy_framing_repeat_filter (.mclk_in(mclk),
        .rst_n_in(rst_n), .link_clk_in(link_clk), .rx_byte_in(rx_byte), .on_boundary_in(onb),
        .line_state_in(ls), .recenter_in(rec), .signal_present_in(sig_ok),
        .clock_present_in(clk_ok), .active_transmit_in(atx), .transmit_parity_error_in(perr),
        .ind_byte_out(ind), .reframe_out(rf), .stuff_byte_out(st), .noise_out(nz),
        .phy_invalid_flag_out(phy_inv), .tx_byte_out(tx));
    // count rising edges so a flag held longer than a cycle still counts once
    always @(posedge mclk) begin
        rf_cnt += int'(rf === 1'b1 && pv[0] !== 1'b1);
        st_cnt += int'(st === 1'b1 && pv[1] !== 1'b1);
        nz_cnt += int'(nz === 1'b1 && pv[2] !== 1'b1);
        pv <= {nz, st, rf};
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [9:0] b, input logic o, input logic r);
        rf_cnt = 0;
        st_cnt = 0;
        nz_cnt = 0;
        i_upstream_station.send(b, o, r);
    endtask
    task automatic jk(input logic o, input logic r, input logic exp);
        send(JK, o, r);
        check(10'(rf_cnt), {9'h0, exp});
    endtask
    task automatic rep(input logic [9:0] b, input logic [9:0] exp);
        send(b, 1'b1, 1'b0);
        check(tx, exp);
    endtask
    task automatic set_ls(input logic [2:0] v);
        @(posedge mclk);
        ls <= v;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_pi();
        // table walked from the top: active idle master halt quiet noise unknown ...
        logic [32:0] seq;
        logic [10:0] exp;
        seq = {3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h0, 3'h2, 3'h1, 3'h2};
        exp = 11'b00111100101;
        for (int i = 10; i >= 0; i--) begin
            set_ls(seq[3*i +: 3]);
            repeat (2) @(posedge mclk);
            #1;
            check({9'h0, phy_inv}, {9'h0, exp[i]});
        end
    endtask
    task automatic t_framing();
        send(HH, 1'b1, 1'b0);
        jk(1'b1, 1'b1, 1'b1);
        check(10'(st_cnt), 10'h001);
        set_ls(`LS_ACTIVE);
        jk(1'b1, 1'b0, 1'b0);
        check(10'(st_cnt), 10'h000);
        send(DD, 1'b1, 1'b0);
        send(DD, 1'b1, 1'b0);
        jk(1'b0, 1'b0, 1'b0);
        send(TR, 1'b1, 1'b0);
        send(DD, 1'b1, 1'b0);
        jk(1'b0, 1'b0, 1'b1);
        send(DD, 1'b1, 1'b0);
        jk(1'b1, 1'b0, 1'b1);
    endtask
    task automatic t_repeat();
        rep(JK, JK);
        rep(DD, DD);
        rep(VV, HH);
        rep(DD, HH);
        rep(DD, II);
        rep(JK, JK);
        rep(NT, ZT);
        check(ind, ZT);
        rep(JK, JK);
        rep(DD, DD);
        rep({1'b1, `SYM_R, 1'b1, `SYM_S}, HH);
        rep(JK, JK);
        @(posedge mclk);
        perr <= 1'b1;
        rep(DD, HH);
        @(posedge mclk);
        perr <= 1'b0;
        rep(JK, JK);
        rep(II, II);
        rep(DD, II);
        rep(JK, JK);
        // off-boundary halt pair after an active jk must start the halt sequence
        send(HH, 1'b0, 1'b0);
        rep(DD, HH);
        @(posedge mclk);
        atx <= 1'b0;
        rep(DD, II);
        @(posedge mclk);
        atx <= 1'b1;
    endtask
    task automatic t_noise();
        i_upstream_station.pins(1'b1, 1'b0);
        send(DD, 1'b1, 1'b0);
        check(10'(nz_cnt), 10'h001);
        i_upstream_station.pins(1'b1, 1'b1);
        send(II, 1'b1, 1'b0);
        check(10'(nz_cnt), 10'h000);
        send(DD, 1'b1, 1'b0);
        check(10'(nz_cnt), 10'h001);
        set_ls(`LS_HALT);
        send(VV, 1'b1, 1'b0);
        check(10'(nz_cnt), 10'h001);
        send(II, 1'b1, 1'b0);
        check(10'(nz_cnt), 10'h000);
        set_ls(`LS_ACTIVE);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        ls = `LS_IDLE;
        atx = 1'b1;
        perr = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_pi();
        set_ls(`LS_IDLE);
        t_framing();
        t_repeat();
        t_noise();
        print_verdict();
    end
    // about 35 bytes of 400 ns each are expected; this is about fourteen times that
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule
